// ===== hw/fault_adc_regs.sv
// Purpose: fault interrupt mask, ADC control and channel disable registers
// Assumes: byte register port driven by the serial register engine
// Notes: interrupt output is a one-cycle request to the pulse generator
//
// Operation
// - Mask bit 7 blocks interrupt on input overvoltage rising edge.
// - Mask bit 6 blocks interrupt on thermal shutdown rising edge.
// - Mask bit 5 blocks interrupt on battery overvoltage rising edge.
// - Mask bit 4 blocks interrupt on safety timer expiry rising edge.
// - Mask bit 3 blocks interrupt on system short rising edge.
// - Mask bit 0 blocks interrupt on buck output fault event.
// - Fault mask at 14h, resets to 00h, watchdog leaves it alone.
// - Reserved mask bits 2:1 and control bits 3:0 read zero.
// - Control at 15h resets 30h; enable bit cleared by watchdog too.
// - Control bit 6 picks one-shot over continuous; register reset clears.
// - Sample speed 5:4 gives 15 to 12 bits; resets to 11.
// - Each set channel disable bit stops that channel converting.
// - Channel disable at 16h resets 00h; watchdog leaves it alone.
// - Channel disable bit 1 is read-only and reads one.
// - One-shot conversion done pulses interrupt unless its mask set.
`timescale 1ns/1ps
module fault_adc_regs
	import charger_regs_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_write_data,
	input wire logic reg_read,
	output logic [7:0] reg_read_data,
	output logic reg_read_valid,
	input wire logic register_reset,
	input wire logic watchdog_expired,
	input wire logic input_overvoltage,
	input wire logic thermal_shutdown,
	input wire logic battery_overvoltage,
	input wire logic safety_timer_expired,
	input wire logic system_short,
	input wire logic buck_output_fault_state,
	input wire logic conversion_done,
	input wire logic conversion_done_irq_mask,
	output logic adc_enable,
	output logic adc_one_shot,
	output logic [1:0] adc_sample_speed,
	output logic [3:0] adc_resolution_bits,
	output logic [CHANNEL_COUNT-1:0] channel_convert,
	output logic interrupt_request
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] fault_interrupt_mask;
		logic [7:0] adc_control;
		logic [7:0] adc_channel_disable;
		logic [7:0] read_data;
		logic read_valid;
		logic irq;
	} bank_state_t;

	bank_state_t state;
	bank_state_t next_state;

	fault_event_if #(.FAULTS(FAULT_COUNT)) events ();

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_view(input bank_state_t s,
		input logic [7:0] addr);
		logic [7:0] value;
		value = UNMAPPED_READ_VALUE;
		case (addr)
			FAULT_INTERRUPT_MASK_ADDR: begin
				value = s.fault_interrupt_mask & FAULT_MASK_WRITABLE;
			end
			ADC_CONTROL_ADDR: begin
				value = s.adc_control & ADC_CONTROL_WRITABLE;
			end
			ADC_CHANNEL_DISABLE_ADDR: begin
				value = (s.adc_channel_disable & CHANNEL_DISABLE_WRITABLE)
					| CHANNEL_DISABLE_READ_ONE;
			end
			default: begin
				value = UNMAPPED_READ_VALUE;
			end
		endcase
		return value;
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [7:0] data, input logic [7:0] writable);
		return (old & ~writable) | (data & writable);
	endfunction

	// ----------------------------------------------------------------
	// Fault edges
	// ----------------------------------------------------------------
	// Mask order matches the fault vector below
	assign events.irq_mask = {
		state.fault_interrupt_mask[INPUT_OVERVOLTAGE_IRQ_MASK_BIT],
		state.fault_interrupt_mask[THERMAL_SHUTDOWN_IRQ_MASK_BIT],
		state.fault_interrupt_mask[BATTERY_OVERVOLTAGE_IRQ_MASK_BIT],
		state.fault_interrupt_mask[SAFETY_TIMER_IRQ_MASK_BIT],
		state.fault_interrupt_mask[SYSTEM_SHORT_IRQ_MASK_BIT],
		state.fault_interrupt_mask[BUCK_OUTPUT_FAULT_IRQ_MASK_BIT]
	};

	fault_edge_detect #(.FAULTS(FAULT_COUNT)) edge_unit (
		.clk(clk),
		.reset_n(reset_n),
		.fault_level({input_overvoltage, thermal_shutdown,
			battery_overvoltage, safety_timer_expired, system_short,
			buck_output_fault_state}),
		.events(events.detector)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.read_valid = reg_read;
		if (reg_read) begin
			next_state.read_data = read_view(state, reg_addr);
		end
		if (reg_write) begin
			case (reg_addr)
				FAULT_INTERRUPT_MASK_ADDR: begin
					next_state.fault_interrupt_mask = merge(
						state.fault_interrupt_mask, reg_write_data,
						FAULT_MASK_WRITABLE);
				end
				ADC_CONTROL_ADDR: begin
					next_state.adc_control = merge(state.adc_control,
						reg_write_data, ADC_CONTROL_WRITABLE);
				end
				ADC_CHANNEL_DISABLE_ADDR: begin
					next_state.adc_channel_disable = merge(
						state.adc_channel_disable, reg_write_data,
						CHANNEL_DISABLE_WRITABLE);
				end
				default: begin
					next_state.adc_control = state.adc_control;
				end
			endcase
		end
		if (watchdog_expired) begin
			next_state.adc_control[ADC_ENABLE_BIT] = 1'b0;
		end
		if (register_reset) begin
			next_state.fault_interrupt_mask = FAULT_INTERRUPT_MASK_RESET;
			next_state.adc_control = ADC_CONTROL_RESET;
			next_state.adc_channel_disable = ADC_CHANNEL_DISABLE_RESET;
		end
		next_state.irq = events.event_request
			| (conversion_done & state.adc_control[ADC_ONE_SHOT_BIT]
			& ~conversion_done_irq_mask);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state.fault_interrupt_mask <= FAULT_INTERRUPT_MASK_RESET;
			state.adc_control <= ADC_CONTROL_RESET;
			state.adc_channel_disable <= ADC_CHANNEL_DISABLE_RESET;
			state.read_data <= 8'h00;
			state.read_valid <= 1'b0;
			state.irq <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_read_data = state.read_data;
	assign reg_read_valid = state.read_valid;
	assign interrupt_request = state.irq;
	assign adc_enable = state.adc_control[ADC_ENABLE_BIT];
	assign adc_one_shot = state.adc_control[ADC_ONE_SHOT_BIT];
	assign adc_sample_speed =
		state.adc_control[ADC_SAMPLE_SPEED_LSB +: 2];
	assign adc_resolution_bits = RESOLUTION_AT_SPEED_ZERO
		- {2'b00, adc_sample_speed};
	// channels, bit 1 skipped since it is not a channel
	assign channel_convert = {CHANNEL_COUNT{adc_enable}}
		& ~{state.adc_channel_disable[7:2], state.adc_channel_disable[0]};

endmodule

// ===== hw/charger_regs_pkg.sv
// Purpose: constants for the fault mask and ADC control register bank
// Assumes: byte-wide registers behind the serial register engine
// Notes: none
package charger_regs_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] FAULT_INTERRUPT_MASK_ADDR = 8'h14;
	localparam logic [7:0] ADC_CONTROL_ADDR = 8'h15;
	localparam logic [7:0] ADC_CHANNEL_DISABLE_ADDR = 8'h16;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] FAULT_INTERRUPT_MASK_RESET = 8'h00;
	localparam logic [7:0] ADC_CONTROL_RESET = 8'h30;
	localparam logic [7:0] ADC_CHANNEL_DISABLE_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Field positions and masks
	// ----------------------------------------------------------------
	localparam int INPUT_OVERVOLTAGE_IRQ_MASK_BIT = 7;
	localparam int THERMAL_SHUTDOWN_IRQ_MASK_BIT = 6;
	localparam int BATTERY_OVERVOLTAGE_IRQ_MASK_BIT = 5;
	localparam int SAFETY_TIMER_IRQ_MASK_BIT = 4;
	localparam int SYSTEM_SHORT_IRQ_MASK_BIT = 3;
	localparam int BUCK_OUTPUT_FAULT_IRQ_MASK_BIT = 0;
	localparam logic [7:0] FAULT_MASK_WRITABLE = 8'hF9;

	localparam int ADC_ENABLE_BIT = 7;
	localparam int ADC_ONE_SHOT_BIT = 6;
	localparam int ADC_SAMPLE_SPEED_LSB = 4;
	localparam logic [7:0] ADC_CONTROL_WRITABLE = 8'hF0;

	localparam logic [7:0] CHANNEL_DISABLE_WRITABLE = 8'hFD;
	localparam logic [7:0] CHANNEL_DISABLE_READ_ONE = 8'h02;

	// Fault vector width shared by both modules
	localparam int FAULT_COUNT = 6;
	localparam int CHANNEL_COUNT = 7;

	// Effective resolution at sample speed code zero
	localparam logic [3:0] RESOLUTION_AT_SPEED_ZERO = 4'hF;

	// Read data for unmapped offsets
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

endpackage

// ===== hw/fault_event_if.sv
// Purpose: carries fault masks and the edge request between modules
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface fault_event_if #(parameter int FAULTS = 6);
	logic [FAULTS-1:0] irq_mask;
	logic event_request;

	modport bank (output irq_mask, input event_request);
	modport detector (input irq_mask, output event_request);
endinterface

// ===== hw/fault_edge_detect.sv
// Purpose: rising edge detection of fault conditions, gated by masks
// Assumes: fault inputs synchronous to clk
// Notes: a fault high out of reset counts as a rising edge
`timescale 1ns/1ps
module fault_edge_detect
	import charger_regs_pkg::*;
#(
	parameter int FAULTS = FAULT_COUNT
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [FAULTS-1:0] fault_level,
	fault_event_if.detector events
);

	// Mask order is fixed by the bank, so only the package width fits
	if (FAULTS != FAULT_COUNT) begin : g_bad_width
		$error("fault_edge_detect: FAULTS must match FAULT_COUNT");
	end

	typedef struct packed {
		logic [FAULTS-1:0] previous;
		logic request;
	} edge_state_t;

	edge_state_t state;
	edge_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.previous = fault_level;
		next_state.request = |(fault_level & ~state.previous
			& ~events.irq_mask);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign events.event_request = state.request;

endmodule

// ===== dv/reg_host.sv
// Purpose: host side of the byte register port
// Assumes: strobes launched on rising edges
// Notes: write data idles at the inverse of the last byte
`timescale 1ns/1ps
module reg_host (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_write,
	output logic [7:0] reg_write_data,
	output logic reg_read,
	input wire logic [7:0] reg_read_data,
	input wire logic reg_read_valid
);
	initial {reg_addr, reg_write, reg_write_data, reg_read} = 18'h0_0000;
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_write <= 1'b1;
		reg_write_data <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_write_data <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		v = reg_read_valid;
		d = reg_read_data;
	endtask
endmodule

// ===== dv/fault_adc_regs_properties.sv
// Purpose: port checks for the register bank
// Assumes: one clock, synchronous active-low reset
// Notes: fault edges are judged by the bench
`timescale 1ns/1ps
module fault_adc_regs_properties
	import charger_regs_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_read_data,
	input wire logic reg_read_valid,
	input wire logic register_reset,
	input wire logic watchdog_expired,
	input wire logic conversion_done,
	input wire logic conversion_done_irq_mask,
	input wire logic adc_enable,
	input wire logic adc_one_shot,
	input wire logic [1:0] adc_sample_speed,
	input wire logic [3:0] adc_resolution_bits,
	input wire logic [CHANNEL_COUNT-1:0] channel_convert,
	input wire logic interrupt_request
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence done_seq;
		conversion_done && adc_one_shot && !conversion_done_irq_mask;
	endsequence
	// Write in the same cycle may legally move the fields
	sequence wd_only_seq;
		watchdog_expired && !register_reset && !reg_write;
	endsequence
	done_irq_a:
		assert property (done_seq |-> ##[1:2] interrupt_request)
		else $error("no done interrupt");
	wd_enable_a:
		assert property (watchdog_expired |=> !adc_enable)
		else $error("enable kept after watchdog");
	wd_keep_a:
		assert property (wd_only_seq |=> $stable(adc_one_shot)
			&& $stable(adc_sample_speed))
		else $error("watchdog moved control fields");
	reg_reset_a:
		assert property (register_reset |=> !adc_enable && !adc_one_shot
			&& adc_sample_speed == 2'b11)
		else $error("control not at defaults");
	resolution_a:
		assert property (adc_resolution_bits
			== 4'hF - {2'b00, adc_sample_speed})
		else $error("resolution wrong");
	channel_off_a:
		assert property (!adc_enable |-> channel_convert == '0)
		else $error("channel converts while disabled");
	read_valid_a:
		assert property (reg_read |=> reg_read_valid)
		else $error("read not answered");
	unmapped_a:
		assert property (reg_read && !(reg_addr inside {8'h14, 8'h15,
			8'h16}) |=> reg_read_data == 8'h00)
		else $error("unmapped read not zero");
endmodule

bind fault_adc_regs fault_adc_regs_properties i_fault_adc_regs_properties (
	.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_write(reg_write), .reg_read(reg_read),
	.reg_read_data(reg_read_data), .reg_read_valid(reg_read_valid),
	.register_reset(register_reset), .watchdog_expired(watchdog_expired),
	.conversion_done(conversion_done),
	.conversion_done_irq_mask(conversion_done_irq_mask),
	.adc_enable(adc_enable), .adc_one_shot(adc_one_shot),
	.adc_sample_speed(adc_sample_speed),
	.adc_resolution_bits(adc_resolution_bits),
	.channel_convert(channel_convert),
	.interrupt_request(interrupt_request));

// ===== dv/fault_adc_regs_test.sv
// Purpose: self-checking bench for the register bank
// Assumes: host model drives the byte port
// Notes: fault vector order buck, short, timer, batt, thermal_shutdown, ovp
`timescale 1ns/1ps
module fault_adc_regs_test;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] ctl = 3'b000;
	logic [5:0] f = 6'h00;
	logic dmask = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic wr_s, rd_s, rvalid, en, one, irq;
	logic [1:0] spd;
	logic [3:0] res;
	logic [6:0] conv;
	int failures = 0;
	int n_tests = 0;
	always #25 clk = ~clk;
	fault_adc_regs i_fault_adc_regs (.clk(clk), .reset_n(reset_n),
		.reg_addr(addr), .reg_write(wr_s), .reg_write_data(wdata),
		.reg_read(rd_s), .reg_read_data(rdata), .reg_read_valid(rvalid),
		.register_reset(ctl[1]), .watchdog_expired(ctl[0]),
		.input_overvoltage(f[5]), .thermal_shutdown(f[4]),
		.battery_overvoltage(f[3]), .safety_timer_expired(f[2]),
		.system_short(f[1]), .buck_output_fault_state(f[0]),
		.conversion_done(ctl[2]), .conversion_done_irq_mask(dmask),
		.adc_enable(en), .adc_one_shot(one), .adc_sample_speed(spd),
		.adc_resolution_bits(res), .channel_convert(conv),
		.interrupt_request(irq));
	reg_host i_reg_host (.clk(clk), .reg_addr(addr), .reg_write(wr_s),
		.reg_write_data(wdata), .reg_read(rd_s), .reg_read_data(rdata),
		.reg_read_valid(rvalid));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		i_reg_host.rd(a, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, e);
	endtask
	task pls(input logic [2:0] m);
		@(posedge clk);
		ctl <= m;
		@(posedge clk);
		ctl <= 3'b000;
	endtask
	task cnt(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (irq === 1'b1) c++;
		end
	endtask
	task t_reset;
		rc(8'h14, 8'h00);
		rc(8'h15, 8'h30);
		rc(8'h16, 8'h02);
		chk({4'h0, res}, 8'h0C);
		$display("end reset test");
	endtask
	task t_access;
		i_reg_host.wr(8'h14, 8'hFF);
		i_reg_host.wr(8'h15, 8'hFF);
		i_reg_host.wr(8'h16, 8'h83);
		#1;
		chk({1'b0, conv}, 8'h3E);
		rc(8'h14, 8'hF9);
		rc(8'h15, 8'hF0);
		rc(8'h16, 8'h83);
		rc(8'h17, 8'h00);
		for (int s = 0; s < 4; s++) begin
			i_reg_host.wr(8'h15, 8'(s << 4));
			#1;
			chk({4'h0, res}, 8'(15 - s));
		end
		$display("end access test");
	endtask
	task t_wd;
		i_reg_host.wr(8'h14, 8'h81);
		i_reg_host.wr(8'h15, 8'hF0);
		i_reg_host.wr(8'h16, 8'h04);
		pls(3'b001);
		rc(8'h15, 8'h70);
		rc(8'h14, 8'h81);
		rc(8'h16, 8'h06);
		pls(3'b010);
		rc(8'h14, 8'h00);
		rc(8'h15, 8'h30);
		rc(8'h16, 8'h02);
		$display("end watchdog test");
	endtask
	task t_fault;
		int pos[6] = '{0, 3, 4, 5, 6, 7};
		int c;
		for (int i = 0; i < 6; i++) begin
			for (int m = 0; m < 2; m++) begin
				i_reg_host.wr(8'h14, 8'(m << pos[i]));
				f[i] <= 1'b1;
				cnt(5, c);
				chk(8'(c), 8'(1 - m));
				f <= 6'h00;
				cnt(3, c);
			end
		end
		$display("end fault test");
	endtask
	task t_done;
		int c;
		for (int k = 0; k < 3; k++) begin
			i_reg_host.wr(8'h15, (k == 2) ? 8'h00 : 8'h40);
			dmask <= (k == 1);
			fork
				pls(3'b100);
				cnt(4, c);
			join
			chk(8'(c), 8'(k == 0));
		end
		$display("end done test");
	endtask
	task final_report;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_access();
		t_wd();
		t_fault();
		t_done();
		final_report();
	end
	initial begin
		#500000;
		failures++;
		$display("MISMATCH %0t timeout", $time);
		final_report();
	end
endmodule
